// ---- rtl/fsspi_supervisor.sv ----
/*
 Fail-safe SPI frame supervision and second supervisor init register.
 Assumes SPI mode with MOSI sampled on rising SCLK, MISO changed on
 falling SCLK, SCLK idle low, and a system clock far above SCLK.
*/
`timescale 1ns/1ps
`include "fsspi_consts.svh"

// Functional notes
// - Count rising SCLK edges while chip select low; flag unless exactly 16.
// - Clock error also reports fail-safe internal clock faults.
// - Flag secured-bits error when write security code mismatches data.
// - Access violation: bad frame, init write in normal mode, bad address.
// - Check parity of received write frames and flag parity error.
// - Error flags clear only on power-on reset, zero after it.
// - Read command 0100010 with zero low bits; reply global flags high.
// - Reply low byte: four error flags, zero, timer disable, aux field.
// - Code bits are not bit5, not bit4, bit7, bit6.
// - Timer disable bit stops 8 s deep fail-safe timer; resets zero.
// - Aux field selects how aux over/undervoltage drive reset/fail-safe.
module fsspi_supervisor (
   input wire logic clk,
   input wire logic rstn,
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic mosi,
   input wire logic [7:0] global_status,
   input wire logic normal_mode,
   input wire logic internal_clk_fault,
   output logic miso,
   output logic miso_oe,
   output logic failsafe_secured_bits_error,
   output logic failsafe_clock_count_error,
   output logic failsafe_access_violation,
   output logic failsafe_parity_error,
   output logic deep_failsafe_timer_disable,
   output logic aux_safety_sel_hi,
   output logic aux_safety_sel_lo,
   output logic aux_ov_to_reset,
   output logic aux_ov_to_failsafe,
   output logic aux_uv_to_reset,
   output logic aux_uv_to_failsafe
);
   import fsspi_pkg::*;

   logic sclk_q;
   logic cs_n_q;
   logic mosi_q;
   logic sclk_d;
   logic cs_n_d;
   fsspi_state_t state;
   fsspi_state_t next_state;
   logic [`FSSPI_CNT_W-1:0] cnt;
   logic [`FSSPI_CNT_W-1:0] next_cnt;
   logic [15:0] rx;
   logic [15:0] next_rx;
   logic [15:0] tx;
   logic [15:0] next_tx;
   logic next_miso;
   logic next_miso_oe;
   logic [3:0] flags;
   logic [3:0] next_flags;
   logic next_dis;
   logic [1:0] aux;
   logic [1:0] next_aux;
   logic [3:0] next_route;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic [6:0] cmd;
   logic is_wr;
   logic is_rd;
   logic len_ok;
   logic par_ok;
   logic sec_ok;
   logic [3:0] sec_exp;
   logic bad_access;

   fsspi_sync #(.RESET_VAL(1'h0)) u_sync_sclk (
      .clk(clk), .rstn(rstn), .pin(sclk), .q(sclk_q)
   );
   fsspi_sync #(.RESET_VAL(1'h1)) u_sync_cs (
      .clk(clk), .rstn(rstn), .pin(chip_select_n), .q(cs_n_q)
   );
   fsspi_sync #(.RESET_VAL(1'h0)) u_sync_mosi (
      .clk(clk), .rstn(rstn), .pin(mosi), .q(mosi_q)
   );

   assign sclk_rise = sclk_q && !sclk_d;
   assign sclk_fall = !sclk_q && sclk_d;
   assign cs_fall = !cs_n_q && cs_n_d;
   assign cs_rise = cs_n_q && !cs_n_d;

   // Frame decode, valid only in the evaluation state
   assign cmd = rx[`FSSPI_CMD_HI:`FSSPI_CMD_LO];
   assign is_wr = (cmd == `FSSPI_WRITE_CMD);
   assign is_rd = (cmd == `FSSPI_READ_CMD);
   assign len_ok = (cnt == 5'(`FSSPI_FRAME_BITS));
   assign par_ok = ((^rx) == `FSSPI_PARITY_ODD);
   assign sec_exp = {!rx[`FSSPI_ZERO_BIT], !rx[`FSSPI_DIS_BIT],
                     rx[`FSSPI_AUX_HI_BIT], rx[`FSSPI_AUX_LO_BIT]};
   assign sec_ok = (rx[`FSSPI_SEC_HI:0] == sec_exp);
   assign bad_access = !(is_wr || is_rd)
      || (is_rd && (rx[7:0] != 8'h00 || rx[`FSSPI_PARITY_BIT]))
      || (is_wr && rx[`FSSPI_ZERO_BIT])
      || (is_wr && normal_mode);

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_rx = rx;
      next_tx = tx;
      next_miso = miso;
      next_miso_oe = !cs_n_q;
      next_flags = flags;
      next_dis = deep_failsafe_timer_disable;
      next_aux = aux;
      if (internal_clk_fault) begin
         next_flags[2] = 1'h1;
      end
      unique case (state)
         FSSPI_IDLE: begin
            if (cs_fall) begin
               next_cnt = '0;
               // Reply built from state at frame start
               next_tx = {global_status, flags, 1'h0,
                          deep_failsafe_timer_disable, aux};
               next_miso = next_tx[15];
               next_state = FSSPI_SHIFT;
            end
         end
         FSSPI_SHIFT: begin
            if (sclk_rise) begin
               next_rx = {rx[14:0], mosi_q};
               if (cnt != `FSSPI_CNT_MAX) begin
                  next_cnt = cnt + 5'h1;
               end
            end
            if (sclk_fall && cnt != '0) begin
               next_tx = {tx[14:0], 1'h0};
               next_miso = next_tx[15];
            end
            if (cs_rise) begin
               next_state = FSSPI_EVAL;
            end
         end
         FSSPI_EVAL: begin
            next_state = FSSPI_IDLE;
            // Flags are sticky; only reset clears them
            if (!len_ok) begin
               next_flags[2] = 1'h1;
            end else begin
               if (bad_access) begin
                  next_flags[1] = 1'h1;
               end
               if (is_wr && !par_ok) begin
                  next_flags[0] = 1'h1;
               end
               if (is_wr && !sec_ok) begin
                  next_flags[3] = 1'h1;
               end
               if (is_wr && !bad_access && par_ok && sec_ok) begin
                  next_aux = rx[`FSSPI_AUX_HI_BIT:`FSSPI_AUX_LO_BIT];
                  next_dis = rx[`FSSPI_DIS_BIT];
               end
            end
         end
         default: begin
            next_state = FSSPI_IDLE;
         end
      endcase
   end

   always_comb begin
      next_route = 4'h0;
      unique case (next_aux)
         2'h0: next_route = 4'h0;
         2'h1: next_route = 4'hE;
         2'h2: next_route = 4'hC;
         2'h3: next_route = 4'hF;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         sclk_d <= 1'h0;
         cs_n_d <= 1'h1;
         state <= FSSPI_IDLE;
         cnt <= '0;
         rx <= 16'h0000;
         tx <= 16'h0000;
         miso <= 1'h0;
         miso_oe <= 1'h0;
         flags <= `FSSPI_FLAGS_RESET;
         deep_failsafe_timer_disable <= `FSSPI_DIS_RESET;
         aux <= `FSSPI_AUX_RESET;
         aux_safety_sel_hi <= 1'h0;
         aux_safety_sel_lo <= 1'h0;
         failsafe_secured_bits_error <= 1'h0;
         failsafe_clock_count_error <= 1'h0;
         failsafe_access_violation <= 1'h0;
         failsafe_parity_error <= 1'h0;
         aux_ov_to_reset <= 1'h0;
         aux_ov_to_failsafe <= 1'h0;
         aux_uv_to_reset <= 1'h0;
         aux_uv_to_failsafe <= 1'h0;
      end else begin
         sclk_d <= sclk_q;
         cs_n_d <= cs_n_q;
         state <= next_state;
         cnt <= next_cnt;
         rx <= next_rx;
         tx <= next_tx;
         miso <= next_miso;
         miso_oe <= next_miso_oe;
         flags <= next_flags;
         deep_failsafe_timer_disable <= next_dis;
         aux <= next_aux;
         aux_safety_sel_hi <= next_aux[1];
         aux_safety_sel_lo <= next_aux[0];
         failsafe_secured_bits_error <= next_flags[3];
         failsafe_clock_count_error <= next_flags[2];
         failsafe_access_violation <= next_flags[1];
         failsafe_parity_error <= next_flags[0];
         aux_ov_to_reset <= next_route[3];
         aux_ov_to_failsafe <= next_route[2];
         aux_uv_to_reset <= next_route[1];
         aux_uv_to_failsafe <= next_route[0];
      end
   end
endmodule : fsspi_supervisor

// ---- rtl/fsspi_consts.svh ----
/*
 Field positions, frame codes and reset values of the fail-safe SPI
 supervision register. Assumes inclusion by bare name from rtl/.
*/
`ifndef FSSPI_CONSTS_SVH
`define FSSPI_CONSTS_SVH

`define FSSPI_FRAME_BITS 16
`define FSSPI_CNT_W 5
`define FSSPI_CNT_MAX 5'h1F
`define FSSPI_CMD_HI 15
`define FSSPI_CMD_LO 9
`define FSSPI_WRITE_CMD 7'h62
`define FSSPI_READ_CMD 7'h22
`define FSSPI_PARITY_BIT 8
`define FSSPI_AUX_HI_BIT 7
`define FSSPI_AUX_LO_BIT 6
`define FSSPI_ZERO_BIT 5
`define FSSPI_DIS_BIT 4
`define FSSPI_SEC_HI 3
`define FSSPI_PARITY_ODD 1'h1
`define FSSPI_AUX_RESET 2'h0
`define FSSPI_DIS_RESET 1'h0
`define FSSPI_FLAGS_RESET 4'h0

`endif

// ---- rtl/fsspi_pkg.sv ----
/*
 Types of the fail-safe SPI supervision block.
 Assumes nothing of its surroundings.
*/
package fsspi_pkg;
   typedef enum logic [1:0] {
      FSSPI_IDLE = 2'h0,
      FSSPI_SHIFT = 2'h1,
      FSSPI_EVAL = 2'h3
   } fsspi_state_t;
endpackage : fsspi_pkg

// ---- rtl/fsspi_sync.sv ----
/*
 Three-stage pin synchroniser with agreement filter.
 Assumes an asynchronous pin input and one system clock.
*/
`timescale 1ns/1ps
module fsspi_sync #(
   parameter logic RESET_VAL = 1'h0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic pin,
   output logic q
);
   logic s1;
   logic s2;
   logic s3;
   logic next_q;

   always_comb begin
      next_q = q;
      if (s2 == s3) begin
         next_q = s3;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s1 <= RESET_VAL;
         s2 <= RESET_VAL;
         s3 <= RESET_VAL;
         q <= RESET_VAL;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         q <= next_q;
      end
   end
endmodule : fsspi_sync

// ---- tb/fsspi_supervisor_chk.sv ----
/* Port checker of the supervision block.
 Assumes binding to fsspi_supervisor. */
`timescale 1ns/1ps
module fsspi_supervisor_chk (
   input wire logic clk,
   input wire logic rstn,
   input wire logic chip_select_n,
   input wire logic internal_clk_fault,
   input wire logic miso_oe,
   input wire logic failsafe_secured_bits_error,
   input wire logic failsafe_clock_count_error,
   input wire logic failsafe_access_violation,
   input wire logic deep_failsafe_timer_disable,
   input wire logic aux_safety_sel_hi,
   input wire logic aux_safety_sel_lo,
   input wire logic aux_ov_to_reset,
   input wire logic aux_uv_to_failsafe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_sec;
      failsafe_secured_bits_error |=> $stable(failsafe_secured_bits_error);
   endproperty
   a_sec: assert property (p_sec)
      else $error("sec flag dropped");
   property p_clk;
      failsafe_clock_count_error |=> failsafe_clock_count_error;
   endproperty
   a_clk: assert property (p_clk)
      else $error("clk flag dropped");
   property p_acc;
      failsafe_access_violation |=> failsafe_access_violation;
   endproperty
   a_acc: assert property (p_acc)
      else $error("acc flag dropped");
   property p_flt;
      internal_clk_fault |-> ##[1:2] failsafe_clock_count_error;
   endproperty
   a_flt: assert property (p_flt)
      else $error("fault not flagged");
   property p_ov;
      aux_ov_to_reset == (aux_safety_sel_hi | aux_safety_sel_lo);
   endproperty
   a_ov: assert property (p_ov)
      else $error("ov decode");
   property p_uv;
      aux_uv_to_failsafe == (aux_safety_sel_hi & aux_safety_sel_lo);
   endproperty
   a_uv: assert property (p_uv)
      else $error("uv decode");
   property p_oe;
      chip_select_n [*8] |-> !miso_oe;
   endproperty
   a_oe: assert property (p_oe)
      else $error("oe while deselected");
   property p_oe_on;
      (!chip_select_n) [*8] |-> miso_oe;
   endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("oe missing in frame");
   property p_cfg;
      !$stable({deep_failsafe_timer_disable, aux_safety_sel_hi,
         aux_safety_sel_lo}) |-> chip_select_n;
   endproperty
   a_cfg: assert property (p_cfg)
      else $error("config moved in frame");
endmodule : fsspi_supervisor_chk
bind fsspi_supervisor fsspi_supervisor_chk fsspi_supervisor_chk_inst (.*);

// ---- tb/fsspi_master.sv ----
/* SPI master model of the microcontroller.
 Assumes the system clock; sclk still low outside frames. */
`timescale 1ns/1ps
module fsspi_master (
   input wire logic clk,
   input wire logic miso,
   input wire logic miso_oe,
   output logic sclk,
   output logic chip_select_n,
   output logic mosi
);
   initial begin
      sclk = 1'h0;
      chip_select_n = 1'h1;
      mosi = 1'h0;
   end
   task xfer(input logic [15:0] f, input int n, output logic [15:0] r);
      int i;
      r = 16'h0000;
      @(posedge clk);
      chip_select_n <= 1'h0;
      mosi <= f[15];
      for (i = 0; i < n; i++) begin
         repeat (8) @(posedge clk);
         // Undriven line reads as the inverse of the last bit
         r = {r[14:0], miso_oe ? miso : ~miso};
         sclk <= 1'h1;
         repeat (8) @(posedge clk);
         sclk <= 1'h0;
         mosi <= f[15 - ((i + 1) % 16)];
      end
      repeat (8) @(posedge clk);
      chip_select_n <= 1'h1;
      mosi <= ~mosi;
      repeat (12) @(posedge clk);
   endtask : xfer
endmodule : fsspi_master

// ---- tb/test_fsspi_supervisor.sv ----
/* Self-checking bench of the supervision block.
 Assumes the master model and the bound checker. */
`timescale 1ns/1ps
module test_fsspi_supervisor;
   logic clk = 1'h0, rstn = 1'h0, normal_mode = 1'h0;
   logic internal_clk_fault = 1'h0;
   logic [7:0] global_status = 8'hA5;
   logic sclk, chip_select_n, mosi, miso, miso_oe;
   logic sec, cke, acc, par, dis, ahi, alo, ovr, ovf, uvr, uvf;
   logic [15:0] rsp;
   logic [3:0] flg;
   logic [2:0] cfg;
   int error_cnt = 0, cmp_count = 0, cyc = 0, a;
   always #4 clk = ~clk;
   fsspi_supervisor fsspi_supervisor_inst (.clk, .rstn, .sclk,
      .chip_select_n, .mosi, .global_status, .normal_mode,
      .internal_clk_fault, .miso, .miso_oe,
      .failsafe_secured_bits_error(sec), .failsafe_clock_count_error(cke),
      .failsafe_access_violation(acc), .failsafe_parity_error(par),
      .deep_failsafe_timer_disable(dis), .aux_safety_sel_hi(ahi),
      .aux_safety_sel_lo(alo), .aux_ov_to_reset(ovr),
      .aux_ov_to_failsafe(ovf), .aux_uv_to_reset(uvr),
      .aux_uv_to_failsafe(uvf));
   fsspi_master fsspi_master_inst (.clk, .miso, .miso_oe, .sclk,
      .chip_select_n, .mosi);
   task report_and_stop;
      $display("checks %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         report_and_stop;
      end
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Odd parity over the whole frame
   function automatic logic [15:0] wr(input logic [2:0] c);
      logic [15:0] f;
      f = {7'h62, 1'h0, c[1:0], 1'h0, c[2], 1'h1, ~c[2], c[1:0]};
      wr = f ^ {7'h00, ~^f, 8'h00};
   endfunction : wr
   task st;
      logic [15:0] d;
      d = 16'hFCE0 >> {cfg[1:0], 2'h0};
      chk({5'h00, sec, cke, acc, par, dis, ahi, alo, ovr, ovf, uvr, uvf},
         {5'h00, flg, cfg, d[3:0]});
   endtask : st
   task wt(input logic [15:0] f, input int n);
      fsspi_master_inst.xfer(f, n, rsp);
      if (n == 16) chk(rsp, {global_status, flg, 1'h0, cfg});
   endtask : wt
   task rst;
      rstn <= 1'h0;
      repeat (10) @(posedge clk);
      rstn <= 1'h1;
      repeat (8) @(posedge clk);
      flg = 4'h0;
      cfg = 3'h0;
      st;
   endtask : rst
   initial begin
      rst;
      for (a = 0; a < 8; a++) begin
         wt(wr(a[2:0]), 16);
         cfg = a[2:0];
         st;
      end
      wt(16'h4400, 16);
      wt(wr(3'h2) ^ 16'h0101, 16);
      flg = 4'h8;
      st;
      wt(wr(3'h2) ^ 16'h0100, 16);
      flg = 4'h9;
      st;
      normal_mode <= 1'h1;
      wt(wr(3'h2), 16);
      normal_mode <= 1'h0;
      flg = 4'hB;
      st;
      wt(wr(3'h2), 15);
      flg = 4'hF;
      st;
      rst;
      internal_clk_fault <= 1'h1;
      @(posedge clk);
      internal_clk_fault <= 1'h0;
      repeat (3) @(posedge clk);
      flg = 4'h4;
      st;
      rst;
      wt(wr(3'h7), 17);
      flg = 4'h4;
      st;
      rst;
      wt(16'h4401, 16);
      flg = 4'h2;
      st;
      rst;
      wt(16'h4600, 16);
      flg = 4'h2;
      st;
      report_and_stop;
   end
endmodule : test_fsspi_supervisor
